// ===== timer8_compare_output_ctc.sv
// Function
// RULE1: Force strobe in non-PWM modes updates waveform output only, no flag or clear.
// RULE2: Counter write blocks compare matches in the next timer tick, even stopped.
// RULE3: Software avoids writing counter equal to compare, or zero when counting down.
// RULE4: Software sets waveform output before making the port pin an output.
// RULE5: Waveform output registers keep their value across mode changes.
// RULE6: Output action bits are unbuffered and apply at the next match or force.
// RULE7: Reset clears every waveform output register to zero.
// RULE8: Nonzero action bits route waveform output to pin; direction stays port's.
// RULE9: Pin override depends only on action bits, never on waveform mode.
// RULE10: Action zero leaves waveform output unchanged at compare matches.
// RULE11: Mode field sets counting; action bits affect only outputs.
// RULE12: Mode 0 counts up without clear and wraps 0xFF to 0x00.
// RULE13: Normal mode sets overflow flag as counter becomes zero; counting never clears it.
// RULE14: Mode 2 clears counter on channel A match; compare A is top.
// RULE15: Clear-on-match mode sets compare flag A each time top is reached.
// RULE16: Compare writes unbuffered; top below count means wrap via 0xFF first.
// RULE17: Action 1 in clear-on-match mode toggles channel A on every match.
// RULE18: Clear-on-match mode sets overflow flag on the 0xFF to 0x00 step.
// RULE19: Compare flag sets one timer tick after counter equals compare value.
// RULE20: Flags clear on interrupt service or on software writing one.
// RULE21: CPU counter write has priority over hardware clear or count.
// RULE22: Clock source zero stops counter; counter stays readable and writable.
// RULE23: Force strobe in PWM modes does nothing and leaves no state.
`timescale 1ns/1ps
`default_nettype none

module timer8_compare_output_ctc (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire logic                   tick_i,
  input  wire logic [2:0]             addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  input  wire logic [2:0]             service_ack_i,
  input  wire logic [1:0]             port_value_i,
  input  wire logic [1:0]             port_dir_i,
  output var  logic [7:0]             rdata_o,
  output var  logic [2:0]             flags_o,
  output var  timer8_pkg::pin_drive_t pin_a_o,
  output var  timer8_pkg::pin_drive_t pin_b_o
);

  // ************************************************************
  // Register state
  // ************************************************************
  timer8_pkg::channel_cfg_t chan_a;
  timer8_pkg::channel_cfg_t chan_b;
  logic [2:0] waveform_mode_field;
  logic [2:0] clock_source_select;
  logic [7:0] counter_value;
  logic       match_block;
  logic       compare_flag_a;
  logic       compare_flag_b;
  logic       overflow_flag;
  logic       wave_output_a;
  logic       wave_output_b;

  localparam logic [7:0] BYTE_ZERO_C = timer8_pkg::BYTE_ZERO;

  // ************************************************************
  // Decode
  // ************************************************************
  logic       wr_ctrl_a;
  logic       wr_ctrl_b;
  logic       wr_counter;
  logic       wr_flags;
  logic       timer_tick;
  logic       non_pwm;
  logic       match_a;
  logic       match_b;
  logic       force_a;
  logic       force_b;
  logic       top_clear;
  logic       overflow_step;
  logic [7:0] next_counter;

  assign wr_ctrl_a  = wr_i && (addr_i == timer8_pkg::ADDR_CONTROL_A);
  assign wr_ctrl_b  = wr_i && (addr_i == timer8_pkg::ADDR_CONTROL_B);
  assign wr_counter = wr_i && (addr_i == timer8_pkg::ADDR_COUNTER);
  assign wr_flags   = wr_i && (addr_i == timer8_pkg::ADDR_FLAGS);

  // The prescaled tick only counts while a clock source is selected.
  assign timer_tick = tick_i && (clock_source_select != timer8_pkg::CLK_SEL_STOP); // RULE22

  // Modes with the low mode bit clear are the non-PWM ones.
  assign non_pwm = ~waveform_mode_field[timer8_pkg::MODE_LOW_LSB];

  assign match_a = timer_tick && !match_block && (counter_value == chan_a.compare); // RULE2
  assign match_b = timer_tick && !match_block && (counter_value == chan_b.compare); // RULE2

  // Force strobes are decoded from the write itself and never stored.
  assign force_a = wr_ctrl_b && wdata_i[timer8_pkg::FORCE_A_BIT] && non_pwm; // RULE1 RULE23
  assign force_b = wr_ctrl_b && wdata_i[timer8_pkg::FORCE_B_BIT] && non_pwm; // RULE1 RULE23

  assign top_clear = (waveform_mode_field == timer8_pkg::MODE_CLEAR)
                     && (counter_value == chan_a.compare); // RULE14 RULE16

  assign overflow_step = timer_tick && (counter_value == timer8_pkg::COUNT_MAX)
                         && (next_counter == timer8_pkg::COUNT_ZERO); // RULE13 RULE18

  // ************************************************************
  // Counter sequence
  // ************************************************************
  always_comb begin
    if (top_clear) begin
      next_counter = timer8_pkg::COUNT_ZERO; // RULE14
    end else begin
      next_counter = counter_value + 8'h01; // RULE12 RULE16
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      counter_value <= timer8_pkg::COUNT_ZERO;
    end else if (wr_counter) begin
      counter_value <= wdata_i; // RULE21
    end else if (timer_tick) begin
      counter_value <= next_counter; // RULE11 RULE12
    end
  end

  // A counter write arms the block until the next timer tick has passed.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      match_block <= 1'b0;
    end else if (wr_counter) begin
      match_block <= 1'b1; // RULE2
    end else if (timer_tick) begin
      match_block <= 1'b0;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chan_a.action                <= timer8_pkg::ACT_NONE;
      chan_b.action                <= timer8_pkg::ACT_NONE;
      waveform_mode_field[1:0]     <= timer8_pkg::MODE_NORMAL[1:0];
    end else if (wr_ctrl_a) begin
      chan_a.action                <= wdata_i[timer8_pkg::ACTION_A_LSB +: 2]; // RULE6
      chan_b.action                <= wdata_i[timer8_pkg::ACTION_B_LSB +: 2]; // RULE6
      waveform_mode_field[1:0]     <= wdata_i[timer8_pkg::MODE_LOW_LSB +: 2];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      waveform_mode_field[2] <= timer8_pkg::MODE_NORMAL[2];
      clock_source_select    <= timer8_pkg::CLK_SEL_STOP;
    end else if (wr_ctrl_b) begin
      waveform_mode_field[2] <= wdata_i[timer8_pkg::MODE_HIGH_BIT];
      clock_source_select    <= wdata_i[timer8_pkg::CLK_SEL_LSB +: 3];
    end
  end

  // Compare values load directly, with no buffering in these modes.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chan_a.compare <= BYTE_ZERO_C;
      chan_b.compare <= BYTE_ZERO_C;
    end else if (wr_i && (addr_i == timer8_pkg::ADDR_COMPARE_A)) begin
      chan_a.compare <= wdata_i; // RULE16
    end else if (wr_i && (addr_i == timer8_pkg::ADDR_COMPARE_B)) begin
      chan_b.compare <= wdata_i;
    end
  end

  // ************************************************************
  // Flags: a set in the same cycle as a clear wins.
  // ************************************************************
  logic [2:0] flag_clear;

  assign flag_clear = service_ack_i | (wr_flags ? wdata_i[2:0] : 3'h0); // RULE20

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= overflow_step
                       || (overflow_flag && !flag_clear[timer8_pkg::OVF_BIT]); // RULE13 RULE18
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      compare_flag_a <= 1'b0;
    end else begin
      compare_flag_a <= match_a
                        || (compare_flag_a && !flag_clear[timer8_pkg::CMP_A_BIT]); // RULE15 RULE19
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      compare_flag_b <= 1'b0;
    end else begin
      compare_flag_b <= match_b
                        || (compare_flag_b && !flag_clear[timer8_pkg::CMP_B_BIT]); // RULE19
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flags_o <= 3'h0;
    end else begin
      flags_o[timer8_pkg::OVF_BIT]   <= overflow_flag;
      flags_o[timer8_pkg::CMP_A_BIT] <= compare_flag_a;
      flags_o[timer8_pkg::CMP_B_BIT] <= compare_flag_b;
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= BYTE_ZERO_C;
    end else if (rd_i) begin
      unique case (addr_i)
        timer8_pkg::ADDR_CONTROL_A: rdata_o <= {chan_a.action, chan_b.action, 2'h0,
                                                waveform_mode_field[1:0]};
        timer8_pkg::ADDR_CONTROL_B: rdata_o <= {4'h0, waveform_mode_field[2],
                                                clock_source_select}; // RULE23
        timer8_pkg::ADDR_COUNTER:   rdata_o <= counter_value; // RULE22
        timer8_pkg::ADDR_COMPARE_A: rdata_o <= chan_a.compare;
        timer8_pkg::ADDR_COMPARE_B: rdata_o <= chan_b.compare;
        timer8_pkg::ADDR_FLAGS:     rdata_o <= {5'h00, compare_flag_b, compare_flag_a,
                                                overflow_flag};
        default:                    rdata_o <= BYTE_ZERO_C;
      endcase
    end else begin
      rdata_o <= BYTE_ZERO_C;
    end
  end

  // ************************************************************
  // Waveform channels and pin override
  // ************************************************************
  timer8_wave_channel wave_a_inst (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .match_i   (match_a),
    .force_i   (force_a),
    .non_pwm_i (non_pwm),
    .action_i  (chan_a.action),
    .wave_o    (wave_output_a)
  );

  timer8_wave_channel wave_b_inst (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .match_i   (match_b),
    .force_i   (force_b),
    .non_pwm_i (non_pwm),
    .action_i  (chan_b.action),
    .wave_o    (wave_output_b)
  );

  timer8_pin_override pin_a_inst (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .action_i     (chan_a.action),
    .wave_i       (wave_output_a),
    .port_value_i (port_value_i[0]),
    .port_dir_i   (port_dir_i[0]),
    .pin_o        (pin_a_o)
  );

  timer8_pin_override pin_b_inst (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .action_i     (chan_b.action),
    .wave_i       (wave_output_b),
    .port_value_i (port_value_i[1]),
    .port_dir_i   (port_dir_i[1]),
    .pin_o        (pin_b_o)
  );

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_force_set;
    force_a && (chan_a.action == timer8_pkg::ACT_SET) && !match_a |=> wave_output_a;
  endproperty
  a_force_set: assert property (p_force_set) else $error("force did not set output"); // RULE1

  property p_force_no_flag;
    force_a && !match_a && !compare_flag_a |=> !compare_flag_a;
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force set flag"); // RULE1

  property p_block;
    wr_counter ##1 (!timer_tick && !wr_counter) ##1 timer_tick |-> !match_a;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked"); // RULE2

  property p_reset_wave;
    disable iff (1'b0) rst_i |=> !wave_output_a && !wave_output_b;
  endproperty
  a_reset_wave: assert property (p_reset_wave) else $error("wave not reset"); // RULE7

  property p_override;
    (chan_a.action != timer8_pkg::ACT_NONE) && port_dir_i[0]
      |=> pin_a_o.enable && (pin_a_o.value == $past(wave_output_a));
  endproperty
  a_override: assert property (p_override) else $error("pin override wrong"); // RULE8

  property p_action_zero;
    (chan_a.action == timer8_pkg::ACT_NONE) && !wr_ctrl_a |=> $stable(wave_output_a);
  endproperty
  a_action_zero: assert property (p_action_zero) else $error("action zero changed"); // RULE10

  property p_wrap;
    (waveform_mode_field == timer8_pkg::MODE_NORMAL) && timer_tick && !wr_counter
      && (counter_value == timer8_pkg::COUNT_MAX) |=> (counter_value == 8'h00) && overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap or overflow wrong"); // RULE12 RULE13

  property p_top_clear;
    (waveform_mode_field == timer8_pkg::MODE_CLEAR) && timer_tick && !wr_counter
      && !match_block && (counter_value == chan_a.compare)
      |=> (counter_value == 8'h00) && compare_flag_a;
  endproperty
  a_top_clear: assert property (p_top_clear) else $error("top clear wrong"); // RULE14 RULE15

  property p_cpu_wins;
    wr_counter |=> counter_value == $past(wdata_i);
  endproperty
  a_cpu_wins: assert property (p_cpu_wins) else $error("counter write lost"); // RULE21

  property p_stopped;
    (clock_source_select == timer8_pkg::CLK_SEL_STOP) && !wr_counter |=> $stable(counter_value);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved"); // RULE22

  property p_pwm_force;
    !non_pwm && wr_ctrl_b |=> $stable(wave_output_a) && $stable(wave_output_b);
  endproperty
  a_pwm_force: assert property (p_pwm_force) else $error("force acted in pwm"); // RULE23

  property p_flag_set_wins;
    match_a && flag_clear[timer8_pkg::CMP_A_BIT] |=> compare_flag_a;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag set lost"); // RULE20

  c_ctc_wrap:    cover property (top_clear && timer_tick);
  c_overflow:    cover property (overflow_step);
  c_force:       cover property (force_a && chan_a.action == timer8_pkg::ACT_TOGGLE);
  c_blocked:     cover property (match_block && timer_tick
                                 && counter_value == chan_a.compare);

endmodule

`default_nettype wire

// ===== timer8_compare_output_ctc_bench.sv
`timescale 1ns/1ps
`default_nettype none

module timer8_compare_output_ctc_bench;
  logic                   mclk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   tick_i = 1'b0;
  logic [2:0]             addr_i = 3'h0;
  logic [7:0]             wdata_i = 8'h00;
  logic                   wr_i = 1'b0;
  logic                   rd_i = 1'b0;
  logic [2:0]             service_ack_i = 3'h0;
  logic [1:0]             port_value_i = 2'h0;
  logic [1:0]             port_dir_i = 2'h0;
  logic [7:0]             rdata_o;
  logic [2:0]             flags_o;
  timer8_pkg::pin_drive_t pin_a_o;
  timer8_pkg::pin_drive_t pin_b_o;
  logic [1:0]             pin_level;
  int                     fail_count = 0;
  int                     tests_run = 0;
  int                     cycles = 0;

  always #2.5 mclk_i = ~mclk_i;

  timer8_compare_output_ctc timer8_compare_output_ctc_i (
    .mclk_i        (mclk_i),
    .rst_i         (rst_i),
    .tick_i        (tick_i),
    .addr_i        (addr_i),
    .wdata_i       (wdata_i),
    .wr_i          (wr_i),
    .rd_i          (rd_i),
    .service_ack_i (service_ack_i),
    .port_value_i  (port_value_i),
    .port_dir_i    (port_dir_i),
    .rdata_o       (rdata_o),
    .flags_o       (flags_o),
    .pin_a_o       (pin_a_o),
    .pin_b_o       (pin_b_o)
  );

  timer8_port_model timer8_port_model_i (
    .mclk_i      (mclk_i),
    .pin_a_i     (pin_a_o),
    .pin_b_i     (pin_b_o),
    .pin_level_o (pin_level)
  );

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      tick_i <= 1'b1;
      @(posedge mclk_i);
      tick_i <= 1'b0;
    end
  endtask

  task automatic chk_flags(input logic [2:0] exp);
    @(posedge mclk_i);
    #1;
    check({5'h00, flags_o}, {5'h00, exp});
  endtask

  task automatic chk_pin(input logic [1:0] exp);
    repeat (2) @(posedge mclk_i);
    #1;
    check({6'h00, pin_level}, {6'h00, exp});
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    rd(timer8_pkg::ADDR_COUNTER, 8'h00);
    rd(3'h6, 8'h00);
    wr(timer8_pkg::ADDR_COMPARE_B, 8'h80);
    rd(timer8_pkg::ADDR_COMPARE_B, 8'h80);
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h40);
    @(posedge mclk_i);
    port_dir_i <= 2'h3;
    chk_pin(2'h0);
    $display("reset test done");
  endtask

  task automatic t_force();
    wr(timer8_pkg::ADDR_COMPARE_A, 8'h50);
    wr(timer8_pkg::ADDR_COUNTER, 8'h10);
    wr(timer8_pkg::ADDR_CONTROL_A, 8'hC0);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h80);
    chk_pin(2'h1);
    chk_flags(3'h0);
    rd(timer8_pkg::ADDR_COUNTER, 8'h10);
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h80);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h80);
    chk_pin(2'h0);
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h70);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'hC0);
    chk_pin(2'h3);
    check({7'h00, pin_a_o.enable}, 8'h01);
    $display("force test done");
  endtask

  task automatic t_normal();
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h00);
    chk_pin(2'h0);
    wr(timer8_pkg::ADDR_COUNTER, 8'hFD);
    ticks(1);
    rd(timer8_pkg::ADDR_COUNTER, 8'hFD);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h01);
    ticks(3);
    rd(timer8_pkg::ADDR_COUNTER, 8'h00);
    chk_flags(3'h1);
    ticks(1);
    chk_flags(3'h1);
    wr(timer8_pkg::ADDR_FLAGS, 8'h01);
    chk_flags(3'h0);
    $display("normal test done");
  endtask

  task automatic t_block();
    wr(timer8_pkg::ADDR_COMPARE_A, 8'h05);
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h40);
    wr(timer8_pkg::ADDR_COUNTER, 8'h05);
    ticks(1);
    chk_flags(3'h0);
    chk_pin(2'h1);
    wr(timer8_pkg::ADDR_COUNTER, 8'h04);
    ticks(2);
    chk_flags(3'h2);
    chk_pin(2'h0);
    rd(timer8_pkg::ADDR_COUNTER, 8'h06);
    @(posedge mclk_i);
    service_ack_i <= 3'h2;
    @(posedge mclk_i);
    service_ack_i <= 3'h0;
    chk_flags(3'h0);
    $display("block test done");
  endtask

  task automatic t_ctc();
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h42);
    wr(timer8_pkg::ADDR_COMPARE_A, 8'h02);
    wr(timer8_pkg::ADDR_COUNTER, 8'h00);
    ticks(3);
    rd(timer8_pkg::ADDR_COUNTER, 8'h00);
    chk_flags(3'h2);
    chk_pin(2'h1);
    wr(timer8_pkg::ADDR_FLAGS, 8'h02);
    wr(timer8_pkg::ADDR_COUNTER, 8'hFE);
    wr(timer8_pkg::ADDR_COMPARE_A, 8'h01);
    ticks(4);
    rd(timer8_pkg::ADDR_COUNTER, 8'h00);
    chk_flags(3'h3);
    chk_pin(2'h0);
    $display("clear on match test done");
  endtask

  task automatic t_pwm();
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h41);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h81);
    chk_pin(2'h0);
    rd(timer8_pkg::ADDR_CONTROL_B, 8'h01);
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h40);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h81);
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h43);
    chk_pin(2'h1);
    rd(timer8_pkg::ADDR_CONTROL_A, 8'h43);
    $display("mode change test done");
  endtask

  // A reset in mid-run must clear a waveform output that was left high.
  task automatic t_rereset();
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    wr(timer8_pkg::ADDR_CONTROL_A, 8'h40);
    chk_pin(2'h0);
    wr(timer8_pkg::ADDR_COMPARE_B, 8'h02);
    wr(timer8_pkg::ADDR_CONTROL_B, 8'h01);
    ticks(3);
    chk_flags(3'h6);
    chk_pin(2'h1);
    $display("second reset test done");
  endtask

  // ************************************************************
  // Main sequence and timeout
  // ************************************************************
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_force();
    t_normal();
    t_block();
    t_ctc();
    t_pwm();
    t_rereset();
    results();
  end
endmodule

`default_nettype wire

// ===== timer8_pin_override.sv
`timescale 1ns/1ps
`default_nettype none

module timer8_pin_override (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire logic [1:0]             action_i,
  input  wire logic                   wave_i,
  input  wire logic                   port_value_i,
  input  wire logic                   port_dir_i,
  output var  timer8_pkg::pin_drive_t pin_o
);

  // ************************************************************
  // Port value override
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_o <= '0;
    end else begin
      pin_o.value  <= (action_i != timer8_pkg::ACT_NONE) ? wave_i : port_value_i; // RULE8 RULE9
      pin_o.enable <= port_dir_i; // RULE8
    end
  end

endmodule

`default_nettype wire

// ===== timer8_pkg.sv
package timer8_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [2:0] ADDR_CONTROL_A  = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_B  = 3'h1;
  localparam logic [2:0] ADDR_COUNTER    = 3'h2;
  localparam logic [2:0] ADDR_COMPARE_A  = 3'h3;
  localparam logic [2:0] ADDR_COMPARE_B  = 3'h4;
  localparam logic [2:0] ADDR_FLAGS      = 3'h5;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ACTION_A_LSB   = 6;
  localparam int ACTION_B_LSB   = 4;
  localparam int MODE_LOW_LSB   = 0;
  localparam int FORCE_A_BIT    = 7;
  localparam int FORCE_B_BIT    = 6;
  localparam int MODE_HIGH_BIT  = 3;
  localparam int CLK_SEL_LSB    = 0;
  localparam int OVF_BIT        = 0;
  localparam int CMP_A_BIT      = 1;
  localparam int CMP_B_BIT      = 2;

  // ************************************************************
  // Codes and values
  // ************************************************************
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_CLEAR    = 3'h2;
  localparam logic [1:0] ACT_NONE      = 2'h0;
  localparam logic [1:0] ACT_TOGGLE    = 2'h1;
  localparam logic [1:0] ACT_CLEAR     = 2'h2;
  localparam logic [1:0] ACT_SET       = 2'h3;
  localparam logic [2:0] CLK_SEL_STOP  = 3'h0;
  localparam logic [7:0] COUNT_MAX     = 8'hFF;
  localparam logic [7:0] COUNT_ZERO    = 8'h00;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic value;
    logic enable;
  } pin_drive_t;

  typedef struct packed {
    logic [1:0] action;
    logic [7:0] compare;
  } channel_cfg_t;

endpackage

// ===== timer8_port_model.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Port pin model
// ************************************************************
// Resolves each pin level; an undriven pin is held high by a pull-up.
module timer8_port_model (
  input  wire logic                   mclk_i,
  input  wire timer8_pkg::pin_drive_t pin_a_i,
  input  wire timer8_pkg::pin_drive_t pin_b_i,
  output var  logic [1:0]             pin_level_o
);
  always_comb begin
    pin_level_o[0] = pin_a_i.enable ? pin_a_i.value : 1'b1;
    pin_level_o[1] = pin_b_i.enable ? pin_b_i.value : 1'b1;
  end
endmodule

`default_nettype wire

// ===== timer8_wave_channel.sv
`timescale 1ns/1ps
`default_nettype none

module timer8_wave_channel (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       match_i,
  input  wire logic       force_i,
  input  wire logic       non_pwm_i,
  input  wire logic [1:0] action_i,
  output var  logic       wave_o
);

  // ************************************************************
  // Waveform output register
  // ************************************************************
  logic event_hit;

  assign event_hit = (match_i || force_i) && non_pwm_i;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wave_o <= 1'b0; // RULE7
    end else if (event_hit) begin // RULE5
      unique case (action_i) // RULE6
        timer8_pkg::ACT_NONE:   wave_o <= wave_o; // RULE10
        timer8_pkg::ACT_TOGGLE: wave_o <= ~wave_o; // RULE17
        timer8_pkg::ACT_CLEAR:  wave_o <= 1'b0;
        timer8_pkg::ACT_SET:    wave_o <= 1'b1;
      endcase
    end
  end

endmodule

`default_nettype wire
